//--- design/fulp_defs.svh
// Constants for the fault unit lock-and-key gate and ping engine.
// Assumes a 12-bit APB4 byte address; included by fulp_top and fulp_top_test.
`ifndef FULP_DEFS_SVH
`define FULP_DEFS_SVH
`define FULP_ADDR_W        12
`define FULP_OFS_CTL_LO    12'h008
`define FULP_OFS_CTL_HI    12'h00c
`define FULP_OFS_KEY       12'hea0
`define FULP_OFS_PCTL      12'hea4
`define FULP_OFS_PNOW      12'hea8
`define FULP_KEY_VALUE     8'hbe
`define FULP_KEY_READ      32'h000000be
`define FULP_CTL_RESET     64'h0000000000000001
`define FULP_CTL_CE_EN_BIT 11
`define FULP_PCTL_EN_BIT   0
`define FULP_PCTL_DIFF_LSB 4
`define FULP_PCTL_DIFF_W   12
`define FULP_PCTL_TO_LSB   16
`define FULP_PCTL_TO_W     16
`define FULP_PNOW_EN_BIT   0
`define FULP_PNOW_ACK_BIT  1
`define FULP_PNOW_TCUI_BIT 2
`define FULP_PNOW_TBUI_BIT 3
`define FULP_PNOW_ID_LSB   8
`define FULP_BLK_W         3
`define FULP_NBLK          8
`define FULP_CNT_W         17
`endif

//--- design/fulp_pkg.sv
// Types shared by the fault unit lock-and-ping logic.
// Constants live in fulp_defs.svh; this package holds only types.
package fulp_pkg;
   typedef enum logic [1:0] {
      PS_IDLE,
      PS_SEND,
      PS_WAIT
   } fulp_ping_state_e;
endpackage : fulp_pkg

//--- design/fulp_top.sv
// Fault unit register gate (lock and key) on an APB4 completer, plus the ping engine.
// Assumes APB4 requester on i_clk, a stream network to remote blocks on i_clk,
// and a Q-Channel clock controller that may be asynchronous.
//
// Behaviour
// - After reset the registers are locked; locked writes except to the key are dropped.
// - Unlock only on Secure full-strobe key write with low byte 0xBE.
// - Any Secure non-key write relocks, except first half of a 64-bit pair.
// - While unlocked, a key write not meeting unlock terms locks again.
// - Key reads 0xBE when unlocked and zero when locked.
// - Non-secure accesses never succeed and never change lock state.
// - Two full-strobe writes to both halves of a 64-bit register need one unlock.
// - The two halves may come upper first or lower first.
// - Background pinging visits one remote block at a time and flags missing replies.
// - Reply timeout comes from the ping control timeout field, in clock cycles.
// - Ping period equals interval difference plus timeout field.
// - In low power, no background pings and no timeout reports; resume after.
// - A Q-Channel request to enter low power is accepted.
// - Each ping-now write with enable launches a ping to a present block; writes made while one still waits share that ping, sent to the last id written.
// - Only a reply from the programmed target sets the reply flag; others dropped.
// - Ping to an absent block is not launched; reply flag stays low.
// - Central inject bit corrupts the outgoing ping packet.
// - Remote inject bit asks the target to corrupt its reply; bad replies are faults.
// - Errors are uncorrectable unless CE enable set; cache RAM errors always refetch.
// - Port is 32 bits, Secure checked by protection bit 1, failures read zero.
`timescale 1ns/1ps
`default_nettype none
`include "fulp_defs.svh"

module fulp_top
   import fulp_pkg::*;
(
   input  wire logic                     i_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_psel,
   input  wire logic                     i_penable,
   input  wire logic                     i_pwrite,
   input  wire logic [`FULP_ADDR_W-1:0]  i_paddr,
   input  wire logic [2:0]               i_pprot,
   input  wire logic [3:0]               i_pstrb,
   input  wire logic [31:0]              i_pwdata,
   output logic      [31:0]              o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   input  wire logic [`FULP_NBLK-1:0]    i_blk_present,
   output logic                          o_ping_valid,
   input  wire logic                     i_ping_ready,
   output logic      [`FULP_BLK_W-1:0]   o_ping_blk,
   output logic                          o_ping_corrupt,
   output logic                          o_ping_reply_inject,
   input  wire logic                     i_ack_valid,
   output logic                          o_ack_ready,
   input  wire logic [`FULP_BLK_W-1:0]   i_ack_blk,
   input  wire logic                     i_ack_corrupt,
   output logic                          o_ack_fault,
   output logic                          o_ping_timeout,
   output logic      [`FULP_BLK_W-1:0]   o_timeout_blk,
   input  wire logic                     i_qreqn,
   output logic                          o_qacceptn,
   output logic                          o_qactive,
   input  wire logic                     i_ram_crc_err,
   output logic                          o_err_ce,
   output logic                          o_err_ue,
   output logic                          o_ram_refetch
);

   // Register state
   logic                           unlocked_r;
   logic                           pair_pend_r;
   logic [`FULP_ADDR_W-1:0]        pair_addr_r;
   logic [63:0]                    ctl_r;
   logic [31:0]                    pctl_r;
   logic [31:0]                    pnow_r;
   logic [31:0]                    rdata_r;
   logic                           ack_flag_nxt;

   // Access decode; protection bit 1 high marks a non-secure access
   wire        acc      = i_psel & i_penable;
   wire        secure   = ~i_pprot[1];
   wire        sec_wr   = acc & i_pwrite & secure;
   wire        full     = (i_pstrb == 4'hf);
   wire        hit_key  = (i_paddr == `FULP_OFS_KEY);
   wire        hit_lo   = (i_paddr == `FULP_OFS_CTL_LO);
   wire        hit_hi   = (i_paddr == `FULP_OFS_CTL_HI);
   wire        hit_pctl = (i_paddr == `FULP_OFS_PCTL);
   wire        hit_pnow = (i_paddr == `FULP_OFS_PNOW);
   wire        key_ok   = sec_wr & hit_key & full
                          & (i_pwdata[7:0] == `FULP_KEY_VALUE);
   wire        wr_ok    = sec_wr & unlocked_r & ~hit_key;
   wire        first_half = wr_ok & full & (hit_lo | hit_hi) & ~pair_pend_r;
   wire        pair_hit = pair_pend_r & wr_ok & full & (i_paddr == pair_addr_r);

   // Lock decision: key writes set or clear, other secure writes relock except the first half of a pair
   wire        unlock_nxt = ~sec_wr  ? unlocked_r :
                            hit_key ? key_ok :
                            first_half;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         unlocked_r  <= 1'b0;
         pair_pend_r <= 1'b0;
         pair_addr_r <= 12'h000;
      end else begin
         unlocked_r  <= unlock_nxt;
         if (sec_wr) begin
            pair_pend_r <= first_half;
            pair_addr_r <= hit_lo ? `FULP_OFS_CTL_HI : `FULP_OFS_CTL_LO;
         end
      end
   end

   // Read data is captured in the setup phase so it leaves a flip-flop
   wire [31:0] rd_mux = ~secure  ? 32'h00000000 :
                        hit_key  ? (unlocked_r ? `FULP_KEY_READ : 32'h00000000) :
                        hit_lo   ? ctl_r[31:0] :
                        hit_hi   ? ctl_r[63:32] :
                        hit_pctl ? pctl_r :
                        hit_pnow ? pnow_r : 32'h00000000;

   always_ff @(posedge i_clk) begin
      if (i_reset) rdata_r <= 32'h00000000;
      else if (i_psel & ~i_penable & ~i_pwrite) rdata_r <= rd_mux;
   end

   // Never stalls and never errors: failed checks behave read-zero, write-ignore
   assign o_prdata  = rdata_r;
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;

   // Ping-now write decode
   wire                    pnow_wr  = wr_ok & hit_pnow;
   wire [`FULP_BLK_W-1:0]  pnow_id  = pnow_r[`FULP_PNOW_ID_LSB +: `FULP_BLK_W];
   wire [`FULP_BLK_W-1:0]  wr_id    = i_pwdata[`FULP_PNOW_ID_LSB +: `FULP_BLK_W];
   wire                    dir_go   = pnow_wr & i_pwdata[`FULP_PNOW_EN_BIT]
                                      & i_blk_present[wr_id];
   logic                   dir_armed_r;
   wire                    ack_dir  = i_ack_valid & dir_armed_r
                                      & (i_ack_blk == pnow_id);

   // Reply flag: an arriving reply beats a software clear in the same cycle
   always_comb begin
      ack_flag_nxt = pnow_wr ? i_pwdata[`FULP_PNOW_ACK_BIT] : pnow_r[`FULP_PNOW_ACK_BIT];
      if (ack_dir) ack_flag_nxt = 1'b1;
   end

   // Register file writes, gated by lock state
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctl_r  <= `FULP_CTL_RESET;
         pctl_r <= 32'h00000000;
         pnow_r <= 32'h00000000;
      end else begin
         if (wr_ok & hit_lo) ctl_r[31:0]  <= i_pwdata;
         if (wr_ok & hit_hi) ctl_r[63:32] <= i_pwdata;
         if (wr_ok & hit_pctl) pctl_r <= i_pwdata;
         if (pnow_wr) pnow_r <= i_pwdata;
         pnow_r[`FULP_PNOW_ACK_BIT] <= ack_flag_nxt;
      end
   end

   // Q-Channel request crosses in through three flops; acts when last two agree
   logic qs1_r, qs2_r, qs3_r, lp_r;
   fulp_ping_state_e st_r;
   logic dir_req_r;
   wire  q_stable = (qs2_r == qs3_r);
   wire  eng_idle = (st_r == PS_IDLE) & ~dir_req_r;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         qs1_r <= 1'b1;
         qs2_r <= 1'b1;
         qs3_r <= 1'b1;
         lp_r  <= 1'b0;
      end else begin
         qs1_r <= i_qreqn;
         qs2_r <= qs1_r;
         qs3_r <= qs2_r;
         if (q_stable & ~qs3_r & eng_idle) lp_r <= 1'b1;
         else if (q_stable & qs3_r) lp_r <= 1'b0;
      end
   end

   assign o_qacceptn = ~lp_r;
   assign o_qactive  = ~eng_idle;

   // Ping control fields
   wire                          bg_en   = pctl_r[`FULP_PCTL_EN_BIT];
   wire [`FULP_PCTL_TO_W-1:0]    to_val  = pctl_r[`FULP_PCTL_TO_LSB +: `FULP_PCTL_TO_W];
   wire [`FULP_PCTL_DIFF_W-1:0]  diff    = pctl_r[`FULP_PCTL_DIFF_LSB +: `FULP_PCTL_DIFF_W];
   wire [`FULP_CNT_W-1:0]        period  = `FULP_CNT_W'(to_val) + `FULP_CNT_W'(diff);

   // Round-robin pick of the next present block at or after the pointer
   logic [`FULP_BLK_W-1:0] bg_idx_r;
   logic [`FULP_BLK_W-1:0] next_blk;
   logic                   any_present;
   always_comb begin
      logic [`FULP_BLK_W-1:0] cand;
      cand        = bg_idx_r;
      next_blk    = bg_idx_r;
      any_present = 1'b0;
      for (int k = `FULP_NBLK - 1; k >= 0; k--) begin
         cand = bg_idx_r + `FULP_BLK_W'(k);
         if (i_blk_present[cand]) begin
            next_blk    = cand;
            any_present = 1'b1;
         end
      end
   end

   // Ping engine: directed requests go first, background only outside low power
   logic [`FULP_CNT_W-1:0]  cnt_r;
   logic                    replied_r;
   logic                    send_dir_r;
   logic [`FULP_BLK_W-1:0]  send_blk_r;
   logic                    send_tcui_r;
   logic                    send_tbui_r;
   // A confirmed low-power request blocks new background pings so the engine drains to idle first
   wire  bg_go    = bg_en & ~lp_r & (qs3_r | ~q_stable) & any_present;
   wire  ack_bg   = i_ack_valid & (st_r == PS_WAIT) & (i_ack_blk == send_blk_r);
   wire  to_hit   = (st_r == PS_WAIT) & (cnt_r == `FULP_CNT_W'(to_val))
                    & ~replied_r & ~ack_bg & ~lp_r;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_r        <= PS_IDLE;
         cnt_r       <= '0;
         replied_r   <= 1'b0;
         send_dir_r  <= 1'b0;
         send_blk_r  <= '0;
         send_tcui_r <= 1'b0;
         send_tbui_r <= 1'b0;
         bg_idx_r    <= '0;
         dir_req_r   <= 1'b0;
         dir_armed_r <= 1'b0;
      end else begin
         if (dir_go) dir_req_r <= 1'b1;
         if (pnow_wr) dir_armed_r <= dir_go;
         case (st_r)
            PS_IDLE: begin
               if (dir_req_r) begin
                  st_r        <= PS_SEND;
                  send_dir_r  <= 1'b1;
                  send_blk_r  <= pnow_id;
                  send_tcui_r <= pnow_r[`FULP_PNOW_TCUI_BIT];
                  send_tbui_r <= pnow_r[`FULP_PNOW_TBUI_BIT];
                  dir_req_r   <= dir_go;
               end else if (bg_go) begin
                  st_r        <= PS_SEND;
                  send_dir_r  <= 1'b0;
                  send_blk_r  <= next_blk;
                  send_tcui_r <= 1'b0;
                  send_tbui_r <= 1'b0;
               end
            end
            PS_SEND: begin
               if (i_ping_ready) begin
                  st_r      <= send_dir_r ? PS_IDLE : PS_WAIT;
                  cnt_r     <= '0;
                  replied_r <= 1'b0;
                  if (!send_dir_r) bg_idx_r <= send_blk_r + 1'b1;
               end
            end
            PS_WAIT: begin
               cnt_r <= cnt_r + 1'b1;
               if (ack_bg) replied_r <= 1'b1;
               if (cnt_r >= period) st_r <= PS_IDLE;
            end
            default: st_r <= PS_IDLE;
         endcase
      end
   end

   assign o_ping_valid        = (st_r == PS_SEND);
   assign o_ping_blk          = send_blk_r;
   assign o_ping_corrupt      = send_tcui_r;
   assign o_ping_reply_inject = send_tbui_r;
   assign o_ack_ready         = 1'b1;

   // Event outputs from flops; o_timeout_blk holds the last timed-out block
   wire ce_en = ctl_r[`FULP_CTL_CE_EN_BIT];
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_ping_timeout <= 1'b0;
         o_timeout_blk  <= '0;
         o_ack_fault    <= 1'b0;
         o_err_ce       <= 1'b0;
         o_err_ue       <= 1'b0;
         o_ram_refetch  <= 1'b0;
      end else begin
         o_ping_timeout <= to_hit;
         if (to_hit) o_timeout_blk <= send_blk_r;
         o_ack_fault    <= i_ack_valid & i_ack_corrupt;
         o_err_ce       <= i_ram_crc_err & ce_en;
         o_err_ue       <= i_ram_crc_err & ~ce_en;
         o_ram_refetch  <= i_ram_crc_err;
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   AST_LOCK_AFTER_RESET: assert property ($past(i_reset) |-> !unlocked_r)
      else $error("not locked after reset");
   AST_UNLOCK: assert property (key_ok |=> unlocked_r)
      else $error("valid key did not unlock");
   AST_RELOCK: assert property (sec_wr & !hit_key & !first_half |=> !unlocked_r)
      else $error("secure write did not relock");
   AST_BAD_KEY: assert property (sec_wr & hit_key & !key_ok |=> !unlocked_r)
      else $error("bad key left unlocked");
   AST_KEY_READ: assert property (i_psel & !i_penable & !i_pwrite & hit_key & !i_pprot[1]
      ##1 i_penable |-> o_prdata == (unlocked_r ? `FULP_KEY_READ : 32'h00000000))
      else $error("key readback wrong");
   AST_NONSEC: assert property (acc & i_pprot[1] |=> unlocked_r == $past(unlocked_r))
      else $error("non-secure access moved lock");
   AST_PAIR: assert property (first_half |=> unlocked_r && pair_pend_r)
      else $error("first half of pair relocked");
   AST_TIMEOUT: assert property (to_hit |=>
      o_ping_timeout && o_timeout_blk == $past(send_blk_r))
      else $error("timeout not reported");
   AST_ABSENT: assert property (pnow_wr & !dir_go & !dir_req_r |=> !dir_req_r)
      else $error("absent block ping launched");
   AST_CE: assert property (i_ram_crc_err & ce_en |=>
      o_err_ce & !o_err_ue & o_ram_refetch)
      else $error("correctable routing wrong");

   COV_UNLOCK_PAIR: cover property (key_ok ##[1:8] first_half ##[1:8] pair_hit);
   COV_TIMEOUT: cover property (o_ping_timeout);
   COV_DIRECTED: cover property (dir_go ##[1:20] ack_dir);
   COV_LOWPOWER: cover property ($rose(lp_r));

endmodule : fulp_top
`default_nettype wire

//--- verif/fulp_remote_model.sv
// Remote block units on the ping stream: take pings, answer after a delay.
// Assumes the design's ping stream on i_clk; mute, delay and stall come from the bench.
`timescale 1ns/1ps
`default_nettype none
module fulp_remote_model (
   input  wire logic       i_clk,
   input  wire logic       i_ping_valid,
   input  wire logic [2:0] i_ping_blk,
   input  wire logic       i_ping_corrupt,
   input  wire logic       i_reply_inject,
   input  wire logic [7:0] i_mute,
   input  wire logic [7:0] i_delay,
   input  wire logic [3:0] i_stall,
   output logic            o_ping_ready,
   output logic            o_ack_valid,
   output logic [2:0]      o_ack_blk,
   output logic            o_ack_corrupt,
   output int              o_bad_pings
);
   logic [35:0] pend_q[$];
   int          cyc = 0;
   int          wait_cnt = 0;

   initial begin
      o_ping_ready = 1'b0;
      o_ack_valid = 1'b0;
      {o_ack_blk, o_ack_corrupt} = 4'h5;
      o_bad_pings = 0;
   end

   // Replies leave in arrival order; idle reply lines invert every cycle, so a stale id is back on them every second cycle
   always @(posedge i_clk) begin
      cyc++;
      if (i_ping_valid && o_ping_ready) begin
         wait_cnt = 0;
         o_bad_pings += i_ping_corrupt;
         if (!i_mute[i_ping_blk])
            pend_q.push_back({cyc + i_delay, i_ping_blk, i_reply_inject});
      end else if (i_ping_valid) begin
         wait_cnt++;
      end
      #1;
      o_ping_ready = (wait_cnt >= i_stall);
      if (pend_q.size() > 0 && pend_q[0][35:4] <= cyc) begin
         {o_ack_blk, o_ack_corrupt} = pend_q[0][3:0];
         o_ack_valid = 1'b1;
         void'(pend_q.pop_front());
      end else begin
         o_ack_valid = 1'b0;
         {o_ack_blk, o_ack_corrupt} = ~{o_ack_blk, o_ack_corrupt};
      end
   end
endmodule : fulp_remote_model
`default_nettype wire

//--- verif/fulp_top_test.sv
// Self-checking bench for the fault unit lock gate and ping engine.
// Assumes fulp_top with its macros; remote units come from fulp_remote_model.
`timescale 1ns/1ps
`default_nettype none
`include "fulp_defs.svh"
module fulp_top_test;
   localparam int T = 20;
   localparam int D = 10;
   localparam logic [11:0] KY = `FULP_OFS_KEY;
   localparam logic [11:0] LO = `FULP_OFS_CTL_LO;
   localparam logic [11:0] HI = `FULP_OFS_CTL_HI;
   localparam logic [11:0] PC = `FULP_OFS_PCTL;
   localparam logic [11:0] PN = `FULP_OFS_PNOW;
   localparam logic [11:0] UM = 12'hd00;
   typedef struct {logic wr; logic ns; logic [3:0] st; logic [11:0] ad;
                   logic [11:0] dt; logic [11:0] ex;} fulp_row_s;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, qreqn = 1, crc = 0;
   logic [11:0] paddr = 0;
   logic [2:0]  pprot = 0, pblk, ablk, tblk, last_blk;
   logic [3:0]  pstrb = 0, stall = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pvalid, pready_s, pcorr, pinj, avalid, afault, tout, acorr;
   logic        qacc, ce, ue, refetch, last_corr, last_inj, slverr, aready, qact, bg_chk = 0;
   logic [7:0]  present = 8'hbf, mute = 8'h00, dly = 8'h05;
   int          errors = 0, tests_run = 0, cyc = 0, pings = 0, faults = 0, tos = 0;
   int          bad_iv = 0, bad_to = 0, hs_cyc = 0, to_dly = 0, bad_pings, p, t;
   // Rows: write?, non-secure?, strobes, address, write data, expected read
   fulp_row_s rows [30] = '{
      '{0,0,4'hf,KY,0,0}, '{1,0,4'hf,LO,12'h801,0}, '{0,0,4'hf,LO,0,1},
      '{1,1,4'hf,KY,12'hbe,0}, '{0,0,4'hf,KY,0,0}, '{1,0,4'h7,KY,12'hbe,0},
      '{0,0,4'hf,KY,0,0}, '{1,0,4'hf,KY,12'h1be,0}, '{0,1,4'hf,KY,0,0},
      '{0,0,4'hf,KY,0,12'hbe}, '{1,1,4'hf,UM,0,0}, '{0,0,4'hf,KY,0,12'hbe},
      '{1,0,4'hf,KY,12'hbf,0}, '{0,0,4'hf,KY,0,0}, '{1,0,4'hf,KY,12'hbe,0},
      '{1,0,4'hf,KY,12'hbe,0}, '{0,0,4'hf,KY,0,12'hbe}, '{1,0,4'hf,HI,0,0},
      '{1,0,4'hf,LO,12'h801,0}, '{0,0,4'hf,LO,0,12'h801}, '{0,0,4'hf,KY,0,0},
      '{1,0,4'hf,KY,12'hbe,0}, '{1,0,4'hf,LO,1,0}, '{1,0,4'hf,HI,0,0},
      '{1,0,4'hf,LO,12'h801,0}, '{0,0,4'hf,LO,0,1}, '{1,0,4'hf,KY,12'hbe,0},
      '{1,0,4'h1,UM,0,0}, '{0,0,4'hf,KY,0,0}, '{0,1,4'hf,LO,0,0}};

   always #2 clk = ~clk;

   fulp_top u_dut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pprot(pprot), .i_pstrb(pstrb),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr),
      .i_blk_present(present), .o_ping_valid(pvalid), .i_ping_ready(pready_s),
      .o_ping_blk(pblk), .o_ping_corrupt(pcorr), .o_ping_reply_inject(pinj),
      .i_ack_valid(avalid), .o_ack_ready(aready), .i_ack_blk(ablk), .i_ack_corrupt(acorr),
      .o_ack_fault(afault), .o_ping_timeout(tout), .o_timeout_blk(tblk), .i_qreqn(qreqn),
      .o_qacceptn(qacc), .o_qactive(qact), .i_ram_crc_err(crc), .o_err_ce(ce), .o_err_ue(ue),
      .o_ram_refetch(refetch));

   fulp_remote_model u_remote (.i_clk(clk), .i_ping_valid(pvalid), .i_ping_blk(pblk),
      .i_ping_corrupt(pcorr), .i_reply_inject(pinj), .i_mute(mute), .i_delay(dly),
      .i_stall(stall), .o_ping_ready(pready_s), .o_ack_valid(avalid), .o_ack_blk(ablk),
      .o_ack_corrupt(acorr), .o_bad_pings(bad_pings));

   // Stream monitor: ping spacing, last ping fields, faults and timeouts
   always @(posedge clk) begin
      cyc++;
      if (pvalid && pready_s) begin
         if (bg_chk && (cyc - hs_cyc < T + D || cyc - hs_cyc > T + D + 4)) bad_iv++;
         {hs_cyc, last_blk, last_corr, last_inj} = {cyc, pblk, pcorr, pinj};
         pings++;
      end
      faults += afault;
      if (tout) begin
         tos++;
         to_dly = cyc - hs_cyc;
         bad_to += (tblk !== 3'h4);
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask : chk

   // One APB transfer; request held until the edge that sees pready high
   task automatic apb(input logic w, input logic ns, input logic [3:0] st,
                      input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      {psel, penable, pwrite, pprot, pstrb, paddr, pwdata} = {2'b10, w, 1'b0, ns, 1'b0, st, a, d};
      @(posedge clk);
      #1;
      penable = 1'b1;
      @(posedge clk);
      for (int k = 0; k < 8 && pready !== 1'b1; k++) @(posedge clk);
      rd = prdata;
      #1;
      {psel, penable} = 2'b00;
   endtask : apb

   task automatic unlock;
      apb(1, 0, 4'hf, KY, 32'h0000_00be);
   endtask : unlock

   task automatic ram(input logic [2:0] exp);
      @(posedge clk);
      #1;
      crc = 1'b1;
      @(posedge clk);
      #1;
      crc = 1'b0;
      chk({ce, ue, refetch}, exp, "ram error class");
   endtask : ram

   // Directed ping the way software should issue it, then poll the reply flag
   task automatic dir(input logic [31:0] v, input int go, input logic flag);
      int p0;
      p0 = pings;
      unlock;
      apb(1, 0, 4'hf, PC, 32'h0);
      unlock;
      apb(1, 0, 4'hf, PN, 32'h0);
      unlock;
      apb(1, 0, 4'hf, PN, v);
      for (int k = 0; k < 40 && pings == p0; k++) @(posedge clk);
      rd = 0;
      for (int k = 0; k < 20 && rd[1] !== 1'b1; k++) apb(0, 0, 4'hf, PN, 32'h0);
      chk(pings - p0, go, "ping count");
      chk(rd[1], flag, "reply flag");
   endtask : dir

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report;
   end

   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({qacc, slverr, aready, qact, pvalid, tout}, 6'b101000, "idle after reset");
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].ns, rows[i].st, rows[i].ad, {20'h0, rows[i].dt});
         if (!rows[i].wr) chk(rd, {20'h0, rows[i].ex}, "register row");
      end
      ram(3'b011);
      unlock;
      apb(1, 0, 4'hf, LO, 32'h801);
      ram(3'b101);
      // Directed pings: slow ready, central inject, remote inject, absent, stale reply
      stall = 4'h2;
      dir(32'h205, 1, 1'b1);
      chk({last_blk, last_corr, 28'(bad_pings)}, {3'h2, 1'b1, 28'h1}, "central inject");
      dir(32'h509, 1, 1'b1);
      chk({last_inj, 31'(faults)}, {1'b1, 31'h1}, "reply inject fault");
      dir(32'h601, 0, 1'b0);
      {mute, dly} = {8'h08, 8'h1e};
      unlock;
      apb(1, 0, 4'hf, PN, 32'h101);
      // Let the first ping leave so only the second one is counted by the next call
      repeat (8) @(posedge clk);
      dir(32'h301, 1, 1'b0);
      // Background pinging with block 4 silent
      {mute, dly, stall} = {8'h10, 8'h03, 4'h0};
      unlock;
      apb(1, 0, 4'hf, PC, {16'(T), 12'(D), 4'h1});
      p = pings;
      for (int k = 0; k < 100 && pings == p; k++) @(posedge clk);
      bg_chk = 1'b1;
      repeat (300) @(posedge clk);
      chk(bad_iv, 0, "ping spacing");
      chk({tos > 0, 31'(bad_to)}, {1'b1, 31'h0}, "timeouts");
      chk(to_dly >= T && to_dly <= T + 4, 1, "timeout delay");
      // Low power: no pings or timeouts, resume on exit
      #1;
      {bg_chk, qreqn} = 2'b00;
      for (int k = 0; k < 300 && qacc !== 1'b0; k++) @(posedge clk);
      chk(qacc, 1'b0, "low power accept");
      {p, t} = {pings, tos};
      repeat (100) @(posedge clk);
      chk({16'(pings - p), 16'(tos - t)}, 32'h0, "quiet in low power");
      #1;
      qreqn = 1'b1;
      for (int k = 0; k < 200 && pings == p; k++) @(posedge clk);
      chk({qacc, pings > p}, 2'b11, "resume after low power");
      final_report;
   end
endmodule : fulp_top_test
`default_nettype wire
